// File: tb/pc_card_slot_controller_tb_top.sv
`timescale 1ns/10ps
`include "pcs_map.svh"
module pc_card_slot_controller_tb_top;
  import pcs_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic regWr = 1'b0, regRd = 1'b0, reqValid = 1'b0;
  pcs_req_s req = '0;
  logic cycBusy, cycDone, cycMiss, cardDataOe, bufferDirection, speakerOut;
  logic [15:0] cycRdata, cardDataOut, cardDataIn, lastWrite;
  logic [25:0] cardAddressBus;
  logic [1:0] slotEvenByteEnableN, slotOddByteEnableN, slotAttrSelectN, slotBufferSelectN;
  logic sharedOutputEnableN, sharedWriteEnableN, ioReadStrobeN, ioWriteStrobeN;
  logic [1:0] slotDetectInputsN = 2'b11, cardPresent, cardReady, slotIrq, slotStatusChange;
  pcs_slot_in_s slotAIn = 4'hF, slotBIn = 4'hF;
  logic keyboardDataPin = 1'b0, keyboardClockPin = 1'b0, kbdDataToCtrl, kbdClockToCtrl;
  logic [6:0] legacyFnIn = 7'h7F, legacyFnOut;
  int n_errors = 0, n_checks = 0;
  logic [1:0] progVoltageOn;
  logic [9:0] win = 10'h000;
  localparam logic [25:0] HI = 26'h3800012; // Bank 7

  pcs_card_slot_ctrl pcs_card_slot_ctrl_inst (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .reqValid(reqValid), .req(req), .cycBusy(cycBusy), .cycDone(cycDone), .cycMiss(cycMiss),
    .cycRdata(cycRdata), .cardAddressBus(cardAddressBus), .cardDataOut(cardDataOut),
    .cardDataOe(cardDataOe), .cardDataIn(cardDataIn), .slotEvenByteEnableN(slotEvenByteEnableN),
    .slotOddByteEnableN(slotOddByteEnableN), .slotAttrSelectN(slotAttrSelectN),
    .slotBufferSelectN(slotBufferSelectN), .bufferDirection(bufferDirection),
    .sharedOutputEnableN(sharedOutputEnableN), .sharedWriteEnableN(sharedWriteEnableN),
    .ioReadStrobeN(ioReadStrobeN), .ioWriteStrobeN(ioWriteStrobeN),
    .slotDetectInputsN(slotDetectInputsN), .slotAIn(slotAIn), .slotBIn(slotBIn),
    .cardPresent(cardPresent), .cardReady(cardReady), .slotIrq(slotIrq),
    .slotStatusChange(slotStatusChange), .speakerOut(speakerOut),
    .keyboardDataPin(keyboardDataPin), .keyboardClockPin(keyboardClockPin),
    .kbdDataToCtrl(kbdDataToCtrl), .kbdClockToCtrl(kbdClockToCtrl),
    .legacyFnIn(legacyFnIn), .legacyFnOut(legacyFnOut), .progVoltageOn(progVoltageOn));

  pcs_card_model pcs_card_model_inst (.clock(clock), .cardAddressBus(cardAddressBus),
    .cardDataOut(cardDataOut), .slotBufferSelectN(slotBufferSelectN),
    .bufferDirection(bufferDirection), .sharedOutputEnableN(sharedOutputEnableN),
    .sharedWriteEnableN(sharedWriteEnableN), .ioReadStrobeN(ioReadStrobeN),
    .ioWriteStrobeN(ioWriteStrobeN), .cardDataIn(cardDataIn), .lastWrite(lastWrite));

  ////////////////////////////////////////////////////////////////
  // Clock, 100 MHz
  always #5 clock = ~clock;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask : rd

  function automatic pcs_req_s mk(logic w, logic io, logic s, logic wd, logic [25:0] a);
    return '{write: w, io: io, attr: 1'b0, slot: s, word: wd, addr: a, wdata: {a[7:0], ~a[7:0]}};
  endfunction : mk

  ////////////////////////////////////////////////////////////////
  // One card cycle; n < 0 means a refusal is expected
  task automatic run(input pcs_req_s r, input int n, input logic act, input logic wide);
    int cnt;
    logic stb, quiet;
    logic [25:0] ea;
    cnt = 0;
    // Low window lands on the programmed page; IO cycles are never remapped
    ea = (!r.io && r.addr[25:16] == `PCS_WIN_BASE) ? {win, r.addr[15:0]} : r.addr;
    @(posedge clock);
    reqValid <= 1'b1;
    req <= r;
    @(posedge clock);
    reqValid <= 1'b0;
    for (int k = 0; k < 60; k++) begin
      #1;
      if (cycDone === 1'b1) break;
      stb = r.io ? (r.write ? ioWriteStrobeN : ioReadStrobeN)
                 : (r.write ? sharedWriteEnableN : sharedOutputEnableN);
      quiet = r.io ? (sharedOutputEnableN & sharedWriteEnableN) : (ioReadStrobeN & ioWriteStrobeN);
      if (stb === 1'b0) begin
        cnt++;
        chk({slotEvenByteEnableN[r.slot], slotOddByteEnableN[r.slot], slotBufferSelectN, quiet,
             bufferDirection, cardAddressBus},
            {act, wide ? act : ~act, r.slot ? 2'b01 : 2'b10, 1'b1, r.write, ea});
        chk({slotAttrSelectN[r.slot], cardDataOe, cycBusy},
            {(r.attr || r.io) ? act : ~act, r.write, 1'b1});
      end
      @(posedge clock);
    end
    chk({cycDone, cycMiss}, {1'b1, n < 0});
    chk(cnt, (n < 0) ? 0 : n);
    if (!r.write && n > 0) begin
      chk(cycRdata, wide ? {r.addr[7:0], ~r.addr[7:0]} : {8'h00, ~r.addr[7:0]});
    end
  endtask : run

  ////////////////////////////////////////////////////////////////
  // Idle pins after reset, refusal with no arrangement
  task automatic t_reset;
    chk({slotEvenByteEnableN, slotBufferSelectN}, 4'hF);
    rd(8'h13, 8'h00);
    run(mk(0, 0, 0, 0, HI), -1, 1'b0, 1'b0);
  endtask : t_reset

  // One slot, slowest timing first, bank and slot refusals
  task automatic t_one;
    wr(8'h13, 8'h00);
    wr(8'h47, 8'h02);
    wr(8'h42, 8'h00);
    wr(8'h43, 8'h01);
    rd(8'h47, 8'h02);
    rd(8'h43, 8'h01);
    rd(8'h7F, 8'h00);
    wr(8'h40, 8'hF5);
    wr(8'h41, 8'h00);
    wr(8'h48, 8'h80);
    #1;
    chk({legacyFnOut, cardReady}, {7'h78, 2'b01});
    run(mk(0, 0, 0, 0, HI), 25, 1'b0, 1'b0);
    run(mk(0, 0, 1, 0, HI), -1, 1'b0, 1'b0);
    run(mk(0, 0, 0, 0, 26'h0000034), -1, 1'b0, 1'b0);
    run(mk(0, 1, 0, 0, HI), -1, 1'b0, 1'b0);
  endtask : t_one

  // Two slots: classes, polarity, IO strobes, keyboard pins
  task automatic t_two;
    int cls[4] = '{25, 20, 15, 15};
    wr(8'h40, 8'hFA);
    wr(8'h41, 8'hC5);
    wr(8'h49, 8'h80);
    keyboardDataPin <= 1'b0;
    slotAIn.readyIrqIn <= 1'b0;
    slotBIn.readyIrqIn <= 1'b0;
    slotBIn.wp16 <= 1'b0;
    slotBIn.batteryStatus1 <= 1'b0;
    slotBIn.batteryStatus2 <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({legacyFnOut, kbdDataToCtrl, kbdClockToCtrl, slotIrq, slotStatusChange, speakerOut},
        {7'h00, 2'b11, 2'b10, 2'b10, 1'b1});
    chk(cardPresent, 2'b10);
    for (int i = 0; i < 4; i++) begin
      wr(8'h13, 8'h80 | 8'(i));
      run(mk(0, 0, 0, 0, HI), cls[i], 1'b1, 1'b0);
    end
    run(mk(0, 1, 1, 1, HI), 15, 1'b0, 1'b1);
    wr(8'h42, 8'h06);
    run(mk(0, 0, 0, 0, HI), 10, 1'b1, 1'b0);
    run(mk(1, 0, 0, 1, HI), 10, 1'b1, 1'b1);
    chk(lastWrite, 16'h12ED);
    run(mk(1, 1, 1, 1, 26'h0000077), 15, 1'b0, 1'b1);
    chk(lastWrite, 16'h7788);
    wr(8'h4A, 8'hC5);
    wr(8'h4B, 8'h03);
    win = 10'h3C5;
    run(mk(0, 0, 0, 0, 26'h00D1234), 10, 1'b1, 1'b0);
    wr(8'h41, 8'hC4);
    slotDetectInputsN <= 2'b10;
    repeat (2) @(posedge clock);
    #1;
    chk({kbdDataToCtrl, cardPresent}, {1'b0, 2'b01});
    chk(progVoltageOn, 2'b01);
  endtask : t_two

  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_one();
    t_two();
    end_of_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
endmodule : pc_card_slot_controller_tb_top

// File: tb/pcs_card_model.sv
`timescale 1ns/10ps
module pcs_card_model (
  // Clock
  input wire logic clock,
  // Card bus from the controller
  input wire logic [25:0] cardAddressBus,
  input wire logic [15:0] cardDataOut,
  input wire logic [1:0] slotBufferSelectN,
  input wire logic bufferDirection,
  input wire logic sharedOutputEnableN,
  input wire logic sharedWriteEnableN,
  input wire logic ioReadStrobeN,
  input wire logic ioWriteStrobeN,
  // Card answer
  output logic [15:0] cardDataIn,
  output logic [15:0] lastWrite
);
  logic [15:0] held = 16'h0000;
  logic sel;
  assign sel = (slotBufferSelectN != 2'b11);
  ////////////////////////////////////////////////////////////////
  // Answer only through a selected buffer; a released bus shows the inverse
  // of the last word, so a stale sample can never pass for a good one
  always @(posedge clock) begin
    if (sel && !bufferDirection && !(sharedOutputEnableN && ioReadStrobeN)) begin
      held <= {cardAddressBus[7:0], ~cardAddressBus[7:0]};
      cardDataIn <= {cardAddressBus[7:0], ~cardAddressBus[7:0]};
    end else begin
      cardDataIn <= ~held;
    end
    if (sel && bufferDirection && !(sharedWriteEnableN && ioWriteStrobeN)) begin
      lastWrite <= cardDataOut;
    end
  end
endmodule : pcs_card_model

// File: verilog/pcs_card_slot_ctrl.sv
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "pcs_map.svh"
module pcs_card_slot_ctrl
  import pcs_pkg::*;
#(
  parameter int CLK_MHZ = `PCS_CLK_MHZ,
  parameter logic [9:0] WIN_BASE = `PCS_WIN_BASE
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Configuration register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Card cycle requests
  input wire logic reqValid,
  input wire pcs_req_s req,
  output logic cycBusy,
  output logic cycDone,
  output logic cycMiss,
  output logic [15:0] cycRdata,
  // Card bus
  output logic [25:0] cardAddressBus,
  output logic [15:0] cardDataOut,
  output logic cardDataOe,
  input wire logic [15:0] cardDataIn,
  output logic [1:0] slotEvenByteEnableN,
  output logic [1:0] slotOddByteEnableN,
  output logic [1:0] slotAttrSelectN,
  output logic [1:0] slotBufferSelectN,
  output logic bufferDirection,
  output logic sharedOutputEnableN,
  output logic sharedWriteEnableN,
  output logic ioReadStrobeN,
  output logic ioWriteStrobeN,
  // Slot status pins
  input wire logic [1:0] slotDetectInputsN,
  input wire pcs_slot_in_s slotAIn,
  input wire pcs_slot_in_s slotBIn,
  output logic [1:0] cardPresent,
  output logic [1:0] cardReady,
  output logic [1:0] slotIrq,
  output logic [1:0] slotStatusChange,
  output logic speakerOut,
  output logic [1:0] progVoltageOn,
  // Shared multipurpose pins
  input wire logic keyboardDataPin,
  input wire logic keyboardClockPin,
  output logic kbdDataToCtrl,
  output logic kbdClockToCtrl,
  input wire logic [6:0] legacyFnIn,
  output logic [6:0] legacyFnOut
);

  // 250 ns must fit the 5-bit cycle counter
  if (CLK_MHZ < 1 || CLK_MHZ > 120) begin : g_bad_clk
    $error("CLK_MHZ outside 1..120");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Least time rounds up, never below one cycle
  function automatic logic [4:0] nsToCyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) c = 1;
    return c[4:0];
  endfunction : nsToCyc
  // Strobe width from class field; fastest class only for SRAM
  function automatic logic [4:0] accessCyc(input logic [7:0] tim, input logic sram);
    logic [4:0] r;
    case (tim[`PCS_TIM_CLASS +: 2])
      2'h1: r = nsToCyc(`PCS_T200_NS);
      2'h2: r = nsToCyc(`PCS_T150_NS);
      2'h3: r = sram ? nsToCyc(`PCS_T100_NS) : nsToCyc(`PCS_T150_NS);
      default: r = nsToCyc(`PCS_T250_NS);
    endcase
    return r;
  endfunction : accessCyc
  // Status byte: mode, present, then raw pins by meaning of the mode
  function automatic logic [7:0] statusByte(input logic [7:0] cfg, input logic pres,
                                            input pcs_slot_in_s p);
    return {cfg[1:0], 2'h0, pres, p.readyIrqIn, p.batteryStatus1, p.batteryStatus2};
  endfunction : statusByte

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  pcs_st_s st_r;
  pcs_st_s st_nxt;
  logic oneSlot, twoSlot, kbdForCard, ioA, ioB, selIo, missReq, wideReq, pol;
  logic presA, presB;
  logic [25:0] effAddr;
  logic [2:0] bank;
  logic [7:0] selTim, selCfg;
  pcs_slot_in_s selIn;
  logic [6:0] ownMask;
  logic [1:0] idleLvl;

  // Pin arrangement patterns, don't-care bits masked
  assign oneSlot = st_r.pinFunctionSelectLo == `PCS_ONE_LO &&
    (st_r.pinFunctionSelectHi & `PCS_ONE_MASK) == `PCS_ONE_HI;
  assign twoSlot = st_r.pinFunctionSelectLo == `PCS_TWO_LO &&
    (st_r.pinFunctionSelectHi & `PCS_TWO_MASK) == `PCS_TWO_HI;
  assign kbdForCard = twoSlot && st_r.pinFunctionSelectHi[`PCS_KBD_BIT];
  assign ownMask = twoSlot ? 7'h7F : (oneSlot ? 7'h07 : 7'h00);

  // Detect: own pins, or one externally ORed line per slot
  assign presA = kbdForCard ? &(~slotDetectInputsN) : ~slotDetectInputsN[0];
  assign presB = twoSlot && (kbdForCard ? ~(keyboardDataPin | keyboardClockPin)
                                        : ~slotDetectInputsN[1]);

  assign ioA = st_r.slotACardConfig[`PCS_CFG_MODE];
  assign ioB = st_r.slotBCardConfig[`PCS_CFG_MODE];

  // Low window swaps in a 10-bit page of the 64MB space
  assign effAddr = (req.addr[25:16] == WIN_BASE) ?
    {st_r.winPageHi[1:0], st_r.winPageLo, req.addr[15:0]} : req.addr;
  assign bank = effAddr[25:23];

  // Selected slot's own settings; the other slot is untouched
  assign selTim = req.slot ? st_r.slotBSignalTiming : st_r.slotASignalTiming;
  assign selCfg = req.slot ? st_r.slotBCardConfig : st_r.slotACardConfig;
  assign selIn = req.slot ? slotBIn : slotAIn;
  assign selIo = req.slot ? ioB : ioA;
  assign pol = selTim[`PCS_TIM_POL];
  assign idleLvl = {~st_r.slotBSignalTiming[`PCS_TIM_POL], ~st_r.slotASignalTiming[`PCS_TIM_POL]};
  // No card cycles until the pins carry card functions
  assign missReq = !(oneSlot || twoSlot) || (req.slot && !twoSlot) ||
    (req.io ? !selIo : !st_r.bankCardSelect[bank]);
  assign wideReq = req.word && (req.io ? !selIn.wp16 : st_r.bankWideSelect[bank]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.miss = 1'b0;
    st_nxt.regRdata = 8'h00;

    // Register writes
    if (regWr) begin
      case (regAddr)
        `PCS_SLOT_A_TIM: st_nxt.slotASignalTiming = regWdata;
        `PCS_SLOT_B_TIM: st_nxt.slotBSignalTiming = regWdata;
        `PCS_PIN_LO: st_nxt.pinFunctionSelectLo = regWdata;
        `PCS_PIN_HI: st_nxt.pinFunctionSelectHi = regWdata;
        `PCS_SLOT_A_CFG: st_nxt.slotACardConfig = regWdata;
        `PCS_SLOT_B_CFG: st_nxt.slotBCardConfig = regWdata;
        `PCS_BANK_CARD: st_nxt.bankCardSelect = regWdata;
        `PCS_BANK_WIDE: st_nxt.bankWideSelect = regWdata;
        `PCS_WIN_LO: st_nxt.winPageLo = regWdata;
        `PCS_WIN_HI: st_nxt.winPageHi = regWdata;
        default: ;
      endcase
    end

    // Register reads, data valid the cycle after only
    if (regRd) begin
      case (regAddr)
        `PCS_SLOT_A_TIM: st_nxt.regRdata = st_r.slotASignalTiming;
        `PCS_SLOT_B_TIM: st_nxt.regRdata = st_r.slotBSignalTiming;
        `PCS_PIN_LO: st_nxt.regRdata = st_r.pinFunctionSelectLo;
        `PCS_PIN_HI: st_nxt.regRdata = st_r.pinFunctionSelectHi;
        `PCS_SLOT_A_CFG: st_nxt.regRdata = st_r.slotACardConfig;
        `PCS_SLOT_B_CFG: st_nxt.regRdata = st_r.slotBCardConfig;
        `PCS_BANK_CARD: st_nxt.regRdata = st_r.bankCardSelect;
        `PCS_BANK_WIDE: st_nxt.regRdata = st_r.bankWideSelect;
        `PCS_WIN_LO: st_nxt.regRdata = st_r.winPageLo;
        `PCS_WIN_HI: st_nxt.regRdata = st_r.winPageHi;
        `PCS_STAT_A: st_nxt.regRdata = statusByte(st_r.slotACardConfig, presA, slotAIn);
        `PCS_STAT_B: st_nxt.regRdata = statusByte(st_r.slotBCardConfig, presB, slotBIn);
        `PCS_PIN_STAT: st_nxt.regRdata = {5'h00, kbdForCard, twoSlot, oneSlot};
        default: st_nxt.regRdata = 8'h00;
      endcase
    end

    // Status pins by mode; slot B only exists with two slots
    st_nxt.present = {presB, presA};
    st_nxt.ready[0] = !ioA && slotAIn.readyIrqIn;
    st_nxt.irq[0] = ioA && !slotAIn.readyIrqIn;
    st_nxt.stsChg[0] = ioA && !slotAIn.batteryStatus1;
    st_nxt.ready[1] = twoSlot && !ioB && slotBIn.readyIrqIn;
    st_nxt.irq[1] = twoSlot && ioB && !slotBIn.readyIrqIn;
    st_nxt.stsChg[1] = twoSlot && ioB && !slotBIn.batteryStatus1;
    st_nxt.spkr = (ioA && !slotAIn.batteryStatus2) ||
                  (twoSlot && ioB && !slotBIn.batteryStatus2);

    // Taken-over pins read as idle to their old consumers
    st_nxt.legacyOut = legacyFnIn & ~ownMask;
    st_nxt.kbdData = kbdForCard ? 1'b1 : keyboardDataPin;
    st_nxt.kbdClock = kbdForCard ? 1'b1 : keyboardClockPin;

    // Card cycle sequencer
    case (st_r.state)
      PCS_IDLE: begin
        st_nxt.evenEnN = idleLvl;
        st_nxt.oddEnN = idleLvl;
        st_nxt.attrSelN = idleLvl;
        if (reqValid && missReq) begin
          st_nxt.done = 1'b1;
          st_nxt.miss = 1'b1;
        end else if (reqValid) begin
          st_nxt.cSlot = req.slot;
          st_nxt.cWrite = req.write;
          st_nxt.cIoStr = req.io;
          st_nxt.wide = wideReq;
          st_nxt.accCyc = accessCyc(selTim, selCfg[`PCS_CFG_SRAM]);
          st_nxt.cardAddr = req.io ? req.addr : effAddr;
          st_nxt.cardDataOut = req.write ? req.wdata : 16'h0000;
          st_nxt.cardDataOe = req.write;
          // Only the addressed slot is enabled, polarity per slot
          st_nxt.evenEnN[req.slot] = pol;
          st_nxt.oddEnN[req.slot] = wideReq ? pol : ~pol;
          st_nxt.attrSelN[req.slot] = (req.attr || req.io) ? pol : ~pol;
          st_nxt.bufSelN[req.slot] = 1'b0;
          st_nxt.dir = req.write;
          st_nxt.cnt = nsToCyc(`PCS_SETUP_NS) - 5'h01;
          st_nxt.state = PCS_SETUP;
        end
      end
      PCS_SETUP: begin
        if (st_r.cnt == 5'h00) begin
          st_nxt.iowN = !(st_r.cIoStr && st_r.cWrite);
          st_nxt.iorN = !(st_r.cIoStr && !st_r.cWrite);
          st_nxt.weN = !(!st_r.cIoStr && st_r.cWrite);
          st_nxt.oeN = !(!st_r.cIoStr && !st_r.cWrite);
          st_nxt.cnt = st_r.accCyc - 5'h01;
          st_nxt.state = PCS_STROBE;
        end else begin
          st_nxt.cnt = st_r.cnt - 5'h01;
        end
      end
      PCS_STROBE: begin
        if (st_r.cnt == 5'h00) begin
          if (!st_r.cWrite) begin
            st_nxt.cycRdata = st_r.wide ? cardDataIn : {8'h00, cardDataIn[7:0]};
          end
          st_nxt.oeN = 1'b1;
          st_nxt.weN = 1'b1;
          st_nxt.iorN = 1'b1;
          st_nxt.iowN = 1'b1;
          st_nxt.cnt = nsToCyc(`PCS_HOLD_NS) - 5'h01;
          st_nxt.state = PCS_HOLD;
        end else begin
          st_nxt.cnt = st_r.cnt - 5'h01;
        end
      end
      PCS_HOLD: begin
        if (st_r.cnt == 5'h00) begin
          // Deselect tri-states the isolation buffers
          st_nxt.evenEnN = idleLvl;
          st_nxt.oddEnN = idleLvl;
          st_nxt.attrSelN = idleLvl;
          st_nxt.bufSelN = 2'h3;
          st_nxt.cardDataOe = 1'b0;
          st_nxt.dir = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.state = PCS_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 5'h01;
        end
      end
      default: st_nxt.state = PCS_IDLE;
    endcase
    st_nxt.busy = st_nxt.state != PCS_IDLE;
  end

  // Reset: slowest class (0) and active-low lines, safe for any card
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.evenEnN <= 2'h3;
      st_r.oddEnN <= 2'h3;
      st_r.attrSelN <= 2'h3;
      st_r.bufSelN <= 2'h3;
      st_r.oeN <= 1'b1;
      st_r.weN <= 1'b1;
      st_r.iorN <= 1'b1;
      st_r.iowN <= 1'b1;
      st_r.kbdData <= 1'b1;
      st_r.kbdClock <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all from the state register
  assign regRdata = st_r.regRdata;
  assign cycBusy = st_r.busy;
  assign cycDone = st_r.done;
  assign cycMiss = st_r.miss;
  assign cycRdata = st_r.cycRdata;
  assign cardAddressBus = st_r.cardAddr;
  assign cardDataOut = st_r.cardDataOut;
  assign cardDataOe = st_r.cardDataOe;
  assign slotEvenByteEnableN = st_r.evenEnN;
  assign slotOddByteEnableN = st_r.oddEnN;
  assign slotAttrSelectN = st_r.attrSelN;
  assign slotBufferSelectN = st_r.bufSelN;
  assign bufferDirection = st_r.dir;
  assign sharedOutputEnableN = st_r.oeN;
  assign sharedWriteEnableN = st_r.weN;
  assign ioReadStrobeN = st_r.iorN;
  assign ioWriteStrobeN = st_r.iowN;
  assign cardPresent = st_r.present;
  assign cardReady = st_r.ready;
  assign slotIrq = st_r.irq;
  assign slotStatusChange = st_r.stsChg;
  assign speakerOut = st_r.spkr;
  assign kbdDataToCtrl = st_r.kbdData;
  assign kbdClockToCtrl = st_r.kbdClock;
  assign legacyFnOut = st_r.legacyOut;
  // Programming voltage switch per slot, straight from the config latch
  assign progVoltageOn = {st_r.slotBCardConfig[`PCS_CFG_VPP],
                          st_r.slotACardConfig[`PCS_CFG_VPP]};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic strobeOn, prevOn;
  logic [4:0] strobeLen, expLen;
  assign strobeOn = !(st_r.oeN && st_r.weN && st_r.iorN && st_r.iowN);
  // Strobe width measured independently of the sequencer counter
  always_ff @(posedge clock) begin
    prevOn <= strobeOn;
    if (strobeOn && !prevOn) begin
      strobeLen <= 5'h01;
      expLen <= st_r.cSlot ?
        accessCyc(st_r.slotBSignalTiming, st_r.slotBCardConfig[`PCS_CFG_SRAM]) :
        accessCyc(st_r.slotASignalTiming, st_r.slotACardConfig[`PCS_CFG_SRAM]);
    end else if (strobeOn) begin
      strobeLen <= strobeLen + 5'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    st_r.state == PCS_IDLE && reqValid && !missReq;
  endsequence
  sequence s_missReq;
    st_r.state == PCS_IDLE && reqValid && missReq && !req.io;
  endsequence
  property p_one_buf;
    !slotBufferSelectN[1] |-> st_r.cSlot && slotBufferSelectN[0];
  endproperty
  a_one_buf: assert property (p_one_buf) else $error("wrong slot buffer selected");
  property p_io_strobe;
    !(ioReadStrobeN && ioWriteStrobeN) |->
      sharedOutputEnableN && sharedWriteEnableN && st_r.cIoStr;
  endproperty
  a_io_strobe: assert property (p_io_strobe) else $error("IO strobe mixed");
  property p_strobe_len;
    $fell(strobeOn) |-> strobeLen == expLen;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width");
  property p_miss;
    s_missReq |=> cycDone && cycMiss && slotBufferSelectN == 2'h3 && !cycBusy;
  endproperty
  a_miss: assert property (p_miss) else $error("non-card bank ran");
  property p_irq_map;
    ioA && !slotAIn.readyIrqIn |=> slotIrq[0] && !cardReady[0];
  endproperty
  a_irq_map: assert property (p_irq_map) else $error("ready not mapped");
  property p_one_pins;
    oneSlot |=> legacyFnOut[2:0] == 3'h0 && legacyFnOut[6:3] == $past(legacyFnIn[6:3]);
  endproperty
  a_one_pins: assert property (p_one_pins) else $error("one-slot pins");
  property p_two_pins;
    twoSlot |=> legacyFnOut == 7'h00;
  endproperty
  a_two_pins: assert property (p_two_pins) else $error("two-slot pins");
  property p_kbd;
    twoSlot && !st_r.pinFunctionSelectHi[`PCS_KBD_BIT] |=>
      kbdDataToCtrl == $past(keyboardDataPin) && kbdClockToCtrl == $past(keyboardClockPin);
  endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard not restored");
  property p_setup;
    s_start |=> cycBusy && bufferDirection == $past(req.write) &&
      cardDataOe == $past(req.write) && !slotBufferSelectN[$past(req.slot)];
  endproperty
  a_setup: assert property (p_setup) else $error("cycle setup");
  property p_done;
    $rose(cycBusy) |-> ##[3:40] (cycDone && !cycBusy);
  endproperty
  a_done: assert property (p_done) else $error("cycle too long");
  property p_width;
    st_r.state == PCS_STROBE |->
      (slotOddByteEnableN[st_r.cSlot] == slotEvenByteEnableN[st_r.cSlot]) == st_r.wide;
  endproperty
  a_width: assert property (p_width) else $error("byte enables");
  property p_window;
    s_start ##0 (!req.io && req.addr[25:16] == WIN_BASE) |=>
      cardAddressBus[25:16] == $past({st_r.winPageHi[1:0], st_r.winPageLo});
  endproperty
  a_window: assert property (p_window) else $error("window remap");
endmodule : pcs_card_slot_ctrl

// File: verilog/pcs_map.svh
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
// How it works
// - One memory/IO mode bit per slot.
// - Slot status pins reinterpreted by mode.
// - Even, odd and attribute enables per slot.
// - Slot A timing 13h, slot B 47h.
// - Slot access speeds set independently.
// - Classes 250, 200, 150; 100 SRAM only.
// - Card cycles address a 64MB space.
// - Low window redirected anywhere in 64MB.
// - Per-bank select enables card cycles.
// - Per-bank select picks 8 or 16 bits.
// - Card pin functions disconnect original functions.
// - 40h F5, 41h 00x0x000 gives one slot.
// - 40h FA, 41h 11x0x10x gives two slots.
// - 41h bit0 clear frees keyboard pins.
// - Per-slot buffer select, shared direction.
// - Programming voltage via external power switch.

// Register offsets
`define PCS_SLOT_A_TIM 8'h13
`define PCS_PIN_LO 8'h40
`define PCS_PIN_HI 8'h41
`define PCS_SLOT_A_CFG 8'h42
`define PCS_SLOT_B_CFG 8'h43
`define PCS_SLOT_B_TIM 8'h47
`define PCS_BANK_CARD 8'h48
`define PCS_BANK_WIDE 8'h49
`define PCS_WIN_LO 8'h4A
`define PCS_WIN_HI 8'h4B
`define PCS_STAT_A 8'h4C
`define PCS_STAT_B 8'h4D
`define PCS_PIN_STAT 8'h4E

// Field positions
`define PCS_CFG_MODE 0
`define PCS_CFG_SRAM 1
`define PCS_CFG_VPP 2
`define PCS_TIM_CLASS 0
`define PCS_TIM_POL 7
`define PCS_KBD_BIT 0

// Reset values and pin patterns
`define PCS_REG_RST 8'h00
`define PCS_ONE_LO 8'hF5
`define PCS_ONE_HI 8'h00
`define PCS_ONE_MASK 8'hD7
`define PCS_TWO_LO 8'hFA
`define PCS_TWO_HI 8'hC4
`define PCS_TWO_MASK 8'hD6
`define PCS_WIN_BASE 10'h00D

// Timing
`define PCS_CLK_MHZ 100
`define PCS_T250_NS 250
`define PCS_T200_NS 200
`define PCS_T150_NS 150
`define PCS_T100_NS 100
`define PCS_SETUP_NS 10
`define PCS_HOLD_NS 10
`endif

// File: verilog/pcs_pkg.sv
package pcs_pkg;
  typedef enum logic [1:0] {PCS_IDLE, PCS_SETUP, PCS_STROBE, PCS_HOLD} pcs_state_e;

  // One card cycle request
  typedef struct packed {
    logic write;
    logic io;
    logic attr;
    logic slot;
    logic word;
    logic [25:0] addr;
    logic [15:0] wdata;
  } pcs_req_s;

  // Per-slot status pins, active low at the card except ready in memory mode
  typedef struct packed {
    logic readyIrqIn;
    logic batteryStatus1;
    logic batteryStatus2;
    logic wp16;
  } pcs_slot_in_s;

  typedef struct packed {
    pcs_state_e state;
    logic [4:0] cnt;
    logic [4:0] accCyc;
    logic [7:0] slotASignalTiming;
    logic [7:0] slotBSignalTiming;
    logic [7:0] pinFunctionSelectLo;
    logic [7:0] pinFunctionSelectHi;
    logic [7:0] slotACardConfig;
    logic [7:0] slotBCardConfig;
    logic [7:0] bankCardSelect;
    logic [7:0] bankWideSelect;
    logic [7:0] winPageLo;
    logic [7:0] winPageHi;
    logic [7:0] regRdata;
    logic cSlot;
    logic cWrite;
    logic cIoStr;
    logic wide;
    logic [25:0] cardAddr;
    logic [15:0] cardDataOut;
    logic cardDataOe;
    logic [1:0] evenEnN;
    logic [1:0] oddEnN;
    logic [1:0] attrSelN;
    logic [1:0] bufSelN;
    logic dir;
    logic oeN;
    logic weN;
    logic iorN;
    logic iowN;
    logic done;
    logic miss;
    logic busy;
    logic [15:0] cycRdata;
    logic [1:0] present;
    logic [1:0] ready;
    logic [1:0] irq;
    logic [1:0] stsChg;
    logic spkr;
    logic [6:0] legacyOut;
    logic kbdData;
    logic kbdClock;
  } pcs_st_s;
endpackage : pcs_pkg
